// file: shared/cabth_pkg.sv
package cabth_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_BLOCK_TX_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TX_HISTORY_READ  = 4'h1;
  localparam int         ADDR_W                = 4;
  localparam int         DATA_W                = 16;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RD_CLEAR_BIT   = 1;
  localparam int RD_TRIGGER_BIT = 0;
  localparam int WR_SET_CLEAR   = 9;
  localparam int WR_SET_TRIG    = 8;
  localparam int WR_CLR_TRIG    = 0;
  localparam int HIST_ENTRY_LSB = 8;
  localparam int HIST_MATCH_BIT = 1;
  localparam int HIST_OVF_BIT   = 0;
  localparam int HIST_OVF_CLR   = 0;
  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int LIST_DEPTH     = 8;
  localparam int OVF_LEVEL      = 7;
  localparam int BUF_NUM_W      = 5;
  localparam int ENTRY_W        = 8;
  localparam int CLEAR_CYCLES   = 4;
endpackage

// file: rtl/cabth_list_mem.sv
module cabth_list_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 5
) (
  // Clock
  input  wire logic                     clk,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("cabth_list_mem: bad size");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // cabth_list_mem

// file: rtl/cabth_ctrl.sv
// How it works
// - Control register starts and clears block engine
// - Control read: clear bit1, trigger bit0, rest zero
// - Write: bit9 sets clear, bit8 sets/bit0 clears trigger
// - History register reads list one entry each
// - History entry field in bits 15:8
// - Match bit1, overflow bit0, bits 7:2 zero
// - Writing bit0 one clears overflow only
// - Each read returns entry at read pointer
// - Entry is buffer number 0 to 31
//
// The placing of the registers and strobed register access were decided locally.
module cabth_ctrl #(
  parameter int CLEAR_CYCLES = cabth_pkg::CLEAR_CYCLES
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [cabth_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cabth_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [cabth_pkg::DATA_W-1:0] reg_rdata,
  // Block engine side
  output logic                              block_tx_trigger,
  output logic                              block_engine_clear,
  input  wire logic                         block_done,
  // Transmit completions
  input  wire logic                         tx_sent,
  input  wire logic [cabth_pkg::BUF_NUM_W-1:0] tx_sent_buf
);
  initial begin
    if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 255) $error("cabth_ctrl: bad CLEAR_CYCLES");
  end

  localparam int PW = $clog2(cabth_pkg::LIST_DEPTH);
  localparam logic [3:0] OVF_CNT = 4'(cabth_pkg::OVF_LEVEL);
  localparam logic [PW-1:0] LAST_SLOT = PW'(cabth_pkg::OVF_LEVEL - 1);
  localparam logic [7:0] CLR_LAST = 8'(CLEAR_CYCLES - 1);

  typedef enum logic [1:0] {CABTH_IDLE, CABTH_CLEARING} cabth_clr_state_t;

  typedef struct packed {
    logic                         trig;
    cabth_clr_state_t             clr_st;
    logic [7:0]                   clr_cnt;
    logic [PW-1:0]                wptr;
    logic [PW-1:0]                rptr;
    logic [3:0]                   unread;
    logic                         ovf;
    logic                         rd_hist;
    logic [cabth_pkg::DATA_W-1:0] rdata;
  } cabth_state_t;

  cabth_state_t st_r;
  cabth_state_t st_nxt;
  logic [cabth_pkg::BUF_NUM_W-1:0] mem_rd;
  logic hit_ctl;
  logic hit_hist;
  logic pop;
  logic push;
  logic full_hold;
  logic [PW-1:0] wr_slot;

  // ----------------------------------------
  // History storage
  // ----------------------------------------
  cabth_list_mem #(
    .DEPTH (cabth_pkg::LIST_DEPTH),
    .WIDTH (cabth_pkg::BUF_NUM_W)
  ) u_mem (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (wr_slot),
    .wr_data (tx_sent_buf),
    .rd_addr (st_r.rptr),
    .rd_data (mem_rd)
  );

  assign hit_ctl  = reg_addr == cabth_pkg::ADDR_BLOCK_TX_CONTROL;
  assign hit_hist = reg_addr == cabth_pkg::ADDR_TX_HISTORY_READ;
  assign pop      = reg_rd && hit_hist && st_r.unread != 4'h0;
  assign push     = tx_sent;

  // ----------------------------------------
  // Write slot
  // ----------------------------------------
  // Full list keeps seven entries; later sends reuse the seventh slot
  assign full_hold = st_r.unread >= OVF_CNT && !pop;
  assign wr_slot   = full_hold ? st_r.wptr - PW'(1) : st_r.wptr;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_hist = 1'b0;
    // Trigger: engine completion clears, software set wins
    if (block_done) begin
      st_nxt.trig = 1'b0;
    end
    if (reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_CLR_TRIG]) begin
      st_nxt.trig = 1'b0;
    end
    if (reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_SET_TRIG]) begin
      st_nxt.trig = 1'b1;
    end
    // Engine clear sequence
    case (st_r.clr_st)
      CABTH_IDLE: begin
        if (reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_SET_CLEAR]) begin
          st_nxt.clr_st  = CABTH_CLEARING;
          st_nxt.clr_cnt = 8'h00;
        end
      end
      CABTH_CLEARING: begin
        if (st_r.clr_cnt == CLR_LAST) begin
          st_nxt.clr_st = CABTH_IDLE;
        end else begin
          st_nxt.clr_cnt = st_r.clr_cnt + 8'h01;
        end
      end
      default: st_nxt.clr_st = CABTH_IDLE;
    endcase
    // History pointers
    if (pop) begin
      st_nxt.rptr = st_r.rptr + PW'(1);
    end
    if (push) begin
      if (st_r.unread >= OVF_CNT - 4'h1 && !pop) begin
        st_nxt.ovf = 1'b1;
      end
      if (st_r.unread < OVF_CNT || pop) begin
        st_nxt.wptr = st_r.wptr + PW'(1);
      end
    end
    case ({push && !(st_r.unread >= OVF_CNT && !pop), pop})
      2'b10:   st_nxt.unread = st_r.unread + 4'h1;
      2'b01:   st_nxt.unread = st_r.unread - 4'h1;
      default: st_nxt.unread = st_r.unread;
    endcase
    // Overflow clear; a new overflow event wins
    if (reg_wr && hit_hist && reg_wdata[cabth_pkg::HIST_OVF_CLR] &&
        !(push && st_r.unread >= OVF_CNT - 4'h1 && !pop)) begin
      st_nxt.ovf = 1'b0;
    end
    // Read data
    st_nxt.rdata = '0;
    if (reg_rd && hit_ctl) begin
      st_nxt.rdata[cabth_pkg::RD_CLEAR_BIT]   = st_r.clr_st == CABTH_CLEARING;
      st_nxt.rdata[cabth_pkg::RD_TRIGGER_BIT] = st_r.trig;
    end
    if (reg_rd && hit_hist) begin
      st_nxt.rd_hist = 1'b1;
      st_nxt.rdata[cabth_pkg::HIST_MATCH_BIT] = st_r.unread == 4'h0;
      st_nxt.rdata[cabth_pkg::HIST_OVF_BIT]   = st_r.ovf;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{trig: 1'b0, clr_st: CABTH_IDLE, clr_cnt: 8'h00, wptr: '0, rptr: '0,
                unread: 4'h0, ovf: 1'b0, rd_hist: 1'b0, rdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    reg_rdata = st_r.rdata;
    if (st_r.rd_hist) begin
      reg_rdata[cabth_pkg::HIST_ENTRY_LSB +: cabth_pkg::ENTRY_W] =
        cabth_pkg::ENTRY_W'(mem_rd);
    end
  end
  assign block_tx_trigger   = st_r.trig;
  assign block_engine_clear = st_r.clr_st == CABTH_CLEARING;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_clear_req;
    reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_SET_CLEAR] && !block_engine_clear;
  endsequence

  a_clear_self_end: assert property (@(posedge clk) disable iff (rst)
    s_clear_req |=> block_engine_clear [*4] ##1 !block_engine_clear)
    else $error("clear status did not end on time");
  a_trig_set_wr: assert property (@(posedge clk) disable iff (rst)
    reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_SET_TRIG] |=> block_tx_trigger)
    else $error("trigger not set");
  a_trig_clr_wr: assert property (@(posedge clk) disable iff (rst)
    reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_CLR_TRIG] && !reg_wdata[cabth_pkg::WR_SET_TRIG]
    |=> !block_tx_trigger)
    else $error("trigger not cleared");
  a_ctl_read_val: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_ctl && !reg_wr |=> reg_rdata == {14'h0000, $past(block_engine_clear), $past(block_tx_trigger)})
    else $error("control read value wrong");
  a_hist_zero_bits: assert property (@(posedge clk) disable iff (rst)
    $past(reg_rd && hit_hist) |-> reg_rdata[7:2] == 6'h00 && reg_rdata[15:13] == 3'h0)
    else $error("history reserved bits set");
  a_match_empty: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_hist && st_r.unread == 4'h0 |=> reg_rdata[cabth_pkg::HIST_MATCH_BIT])
    else $error("match flag wrong");
  a_ovf_set: assert property (@(posedge clk) disable iff (rst)
    push && !pop && st_r.unread == 4'h6 |=> st_r.ovf && st_r.unread == 4'h7)
    else $error("overflow not set at seven");
  a_ovf_clear: assert property (@(posedge clk) disable iff (rst)
    reg_wr && hit_hist && reg_wdata[cabth_pkg::HIST_OVF_CLR] && !push |=> !st_r.ovf)
    else $error("overflow not cleared");
  a_pop_ptr: assert property (@(posedge clk) disable iff (rst)
    pop |=> st_r.rptr == $past(st_r.rptr) + PW'(1))
    else $error("read pointer not advanced");

  // ----------------------------------------
  // Further checks
  // ----------------------------------------
  sequence s_ctl_read;
    reg_rd && hit_ctl;
  endsequence

  sequence s_empty_read;
    reg_rd && hit_hist && st_r.unread == 4'h0;
  endsequence

  sequence s_full_push;
    push && !pop && st_r.unread == OVF_CNT;
  endsequence

  a_ctl_upper_zero: assert property (@(posedge clk) disable iff (rst)
    s_ctl_read |=> reg_rdata[15:2] == 14'h0000)
    else $error("control reserved bits set");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && !hit_ctl && !hit_hist |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_empty_ptr_hold: assert property (@(posedge clk) disable iff (rst)
    s_empty_read |=> $stable(st_r.rptr))
    else $error("read pointer moved on empty list");
  a_full_wptr_hold: assert property (@(posedge clk) disable iff (rst)
    s_full_push |=> st_r.wptr == $past(st_r.wptr) && st_r.unread == OVF_CNT)
    else $error("write pointer moved on full list");
  a_ovf_hold: assert property (@(posedge clk) disable iff (rst)
    st_r.ovf && !(reg_wr && hit_hist && reg_wdata[cabth_pkg::HIST_OVF_CLR]) |=> st_r.ovf)
    else $error("overflow dropped by itself");
  a_unread_max: assert property (@(posedge clk) disable iff (rst)
    st_r.unread <= OVF_CNT)
    else $error("unread count above limit");
  a_trig_done: assert property (@(posedge clk) disable iff (rst)
    block_done && !(reg_wr && hit_ctl && reg_wdata[cabth_pkg::WR_SET_TRIG]) |=> !block_tx_trigger)
    else $error("trigger not cleared on completion");
  a_clear_busy: assert property (@(posedge clk) disable iff (rst)
    block_engine_clear && st_r.clr_cnt != CLR_LAST |=> block_engine_clear)
    else $error("clear status ended early");
endmodule // cabth_ctrl

// file: test/cabth_tb.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                clk;
  logic                                rst;
  logic [cabth_pkg::ADDR_W-1:0]    reg_addr;
  logic [cabth_pkg::DATA_W-1:0]    reg_wdata;
  logic                                reg_wr;
  logic                                reg_rd;
  logic [cabth_pkg::DATA_W-1:0]    reg_rdata;
  logic                                block_tx_trigger;
  logic                                block_engine_clear;
  logic                                block_done;
  logic                                tx_sent;
  logic [cabth_pkg::BUF_NUM_W-1:0] tx_sent_buf;
  logic [15:0]                         d;
  logic [4:0]                          b[9];
  int                                  errors;
  int                                  checked;
  int                                  k;

  cabth_ctrl dut (
    .clk                (clk),
    .rst                (rst),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .block_tx_trigger   (block_tx_trigger),
    .block_engine_clear (block_engine_clear),
    .block_done         (block_done),
    .tx_sent            (tx_sent),
    .tx_sent_buf        (tx_sent_buf)
  );

  always #5 clk = ~clk;

  // ----------------------------------------
  // Bus and event tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic snd(input logic [4:0] n);
    @(posedge clk);
    tx_sent     <= 1'b1;
    tx_sent_buf <= n;
    @(posedge clk);
    tx_sent <= 1'b0;
  endtask

  function automatic logic [15:0] hist_word(input logic [4:0] e, input logic m, input logic o);
    return {3'h0, e, 6'h00, m, o};
  endfunction

  task automatic close_out;
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk, reg_wr, reg_rd, block_done, tx_sent} = 5'h00;
    {reg_addr, reg_wdata, tx_sent_buf} = '0;
    rst = 1'b1;
    errors = 0;
    checked = 0;
    void'($urandom(28));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK({block_tx_trigger, block_engine_clear}, 2'h0)
    rd(4'h0, d); `CHK(d, 16'h0000)
    rd(4'h1, d); `CHK(d[7:0], 8'h02)
    rd(4'h5, d); `CHK(d, 16'h0000)
    wr(4'h0, 16'h0100); `CHK(block_tx_trigger, 1'b1)
    rd(4'h0, d); `CHK(d, 16'h0001)
    wr(4'h0, 16'h0001); `CHK(block_tx_trigger, 1'b0)
    wr(4'h0, 16'h0100);
    @(posedge clk);
    block_done <= 1'b1;
    @(posedge clk);
    block_done <= 1'b0;
    #1 `CHK(block_tx_trigger, 1'b0)
    wr(4'h0, 16'h0200);
    for (int i = 0; i < 4; i++) begin
      `CHK(block_engine_clear, 1'b1)
      @(posedge clk);
      #1;
    end
    `CHK(block_engine_clear, 1'b0)
    rd(4'h0, d); `CHK(d, 16'h0000)
    // Short list, read back in order
    k = $urandom_range(6, 1);
    for (int i = 0; i < k; i++) b[i] = 5'($urandom_range(31));
    for (int i = 0; i < k; i++) snd(b[i]);
    for (int i = 0; i < k; i++) begin
      rd(4'h1, d); `CHK(d & 16'hFFFD, hist_word(b[i], 1'b0, 1'b0))
    end
    rd(4'h1, d); `CHK(d[7:0], 8'h02)
    // Overflow: last slot overwritten
    for (int i = 0; i < 9; i++) b[i] = 5'($urandom_range(31));
    b[0] = 5'h00;
    b[8] = 5'h1F;
    for (int i = 0; i < 9; i++) snd(b[i]);
    for (int i = 0; i < 7; i++) begin
      rd(4'h1, d); `CHK(d & 16'hFFFD, hist_word(b[i < 6 ? i : 8], 1'b0, 1'b1))
    end
    rd(4'h1, d); `CHK(d[7:0], 8'h03)
    wr(4'h1, 16'hFFFE);
    rd(4'h1, d); `CHK(d[7:0], 8'h03)
    wr(4'h1, 16'h0001);
    rd(4'h1, d); `CHK(d[7:0], 8'h02)
    close_out;
  end

  initial begin
    #500000;
    errors++;
    close_out;
  end
endmodule // testbench
